/* File: verilog/tcp_params.svh */
`ifndef TCP_PARAMS_SVH
`define TCP_PARAMS_SVH

// effective register-select codes
`define TCP_SEL_PAL_WPTR  3'h0
`define TCP_SEL_PAL_DATA  3'h1
`define TCP_SEL_MASK      3'h2
`define TCP_SEL_PAL_RPTR  3'h3
`define TCP_SEL_OVL_WPTR  3'h4
`define TCP_SEL_OVL_DATA  3'h5
`define TCP_SEL_CMD_A     3'h6
`define TCP_SEL_OVL_RPTR  3'h7

// indirect targets behind the mask select, by pointer value
`define TCP_OFF_PIXEL_MASK    8'h00
`define TCP_OFF_OVERLAY_MASK  8'h01
`define TCP_OFF_SECOND_CMD    8'h02

// command register A fields
`define TCP_A_EXT_ACCESS_BIT  0
`define TCP_A_BGR_BIT         1
`define TCP_A_FORCE_TOP_BIT   2
`define TCP_A_MODE_HI         7
`define TCP_A_MODE_LO         4

// pixel modes held in command register A bits 7:4
`define TCP_MODE_PSEUDO       4'h0
`define TCP_MODE_555_DUAL     4'h1
`define TCP_MODE_555_SINGLE   4'h2
`define TCP_MODE_565_DUAL     4'h3
`define TCP_MODE_565_SINGLE   4'h4
`define TCP_MODE_24_SINGLE    4'h5
`define TCP_MODE_32_DUAL      4'h6

// reset values
`define TCP_RST_CMD_A         8'h00
`define TCP_RST_SECOND_CMD    8'h00
`define TCP_RST_PIXEL_MASK    8'hff
`define TCP_RST_OVERLAY_MASK  8'hff

// consecutive mask reads that arm the command A redirect
`define TCP_MASK_READS        3'h4
// last colour phase (blue) of the modulo-three counter
`define TCP_PHASE_BLUE        2'h2

// pin synchroniser: {pix_clk, blank_n, pix_data, rd_n, wr_n, select, data}
`define TCP_SYNC_W            23
`define TCP_SYNC_RST          23'h001800

`define TCP_FIFO_DEPTH        32

`endif

/* File: verilog/tcp_pkg.sv */
`default_nettype none

package tcp_pkg;

	typedef struct packed {
		logic [7:0] red;
		logic [7:0] green;
		logic [7:0] blue;
	} tcp_rgb_t;

	// one assembled pixel as it travels through the fifo
	typedef struct packed {
		logic       pseudo;
		logic [7:0] index;
		tcp_rgb_t   color;
	} tcp_pix_word_t;

	typedef logic [3:0] tcp_mode_t;

endpackage : tcp_pkg

`default_nettype wire

/* File: verilog/tcp_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module tcp_sync #(
	parameter int              W   = 1,
	parameter logic [W-1:0]    RST = '0
) (
	input  wire logic         clk_sys,  // system clock
	input  wire logic         arst_n,   // async reset
	input  wire logic [W-1:0] pin_i,    // raw pins
	output logic      [W-1:0] sync_o    // filtered levels
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s1_q <= RST;
			s2_q <= RST;
			s3_q <= RST;
		end else begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a change is accepted only once stages two and three agree
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk_sys or negedge arst_n) begin
				if (!arst_n) begin
					sync_o[i] <= RST[i];
				end else if (s2_q[i] == s3_q[i]) begin
					sync_o[i] <= s3_q[i];
				end
			end
		end
	endgenerate

endmodule : tcp_sync

`default_nettype wire

/* File: verilog/tcp_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

module tcp_fifo #(
	parameter int W = 8,
	parameter int D = 32
) (
	input  wire logic         clk_sys,    // system clock
	input  wire logic         arst_n,     // async reset
	input  wire logic         in_valid,   // push request
	output logic              in_ready,   // not full
	input  wire logic [W-1:0] in_data,    // push data
	output logic              out_valid,  // not empty
	input  wire logic         out_ready,  // pop request
	output logic      [W-1:0] out_data    // head entry
);

	localparam int AW = $clog2(D);

	logic [W-1:0] mem_q [D];
	logic [AW:0]  wr_q;
	logic [AW:0]  rd_q;
	logic         push;
	logic         pop;

	assign in_ready  = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
	assign out_valid = (wr_q != rd_q);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_q[rd_q[AW-1:0]];

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_q[wr_q[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end

endmodule : tcp_fifo

`default_nettype wire

/* File: verilog/tcp_top.sv */
`include "tcp_params.svh"
`timescale 1ns/1ps
`default_nettype none

module tcp_top (
	input  wire logic              clk_sys,         // system clock, 200 MHz
	input  wire logic              arst_n,          // async reset
	input  wire logic              pix_clk,         // pixel clock pin
	input  wire logic              blank_n,         // blanking pin, low blanks
	input  wire logic [7:0]        pix_data,        // pixel port
	input  wire logic              host_rd_n,       // host read strobe
	input  wire logic              host_wr_n,       // host write strobe
	input  wire logic [2:0]        reg_select,      // host register select
	input  wire logic [7:0]        host_d_i,        // host data in
	output logic      [7:0]        host_d_o,        // host data out
	output logic                   host_d_oe_n,     // low while driving data
	output tcp_pkg::tcp_rgb_t      dac_rgb,         // colour to the DACs
	output logic                   dac_valid,       // colour valid
	input  wire logic              dac_ready,       // DAC side accepts
	output logic                   pix_in_ready,    // fifo has room
	output logic      [7:0]        second_command   // second command register
);

	logic [`TCP_SYNC_W-1:0] sync_s;
	logic                   pclk_s;
	logic                   blank_n_s;
	logic [7:0]             pdata_s;
	logic                   rd_n_s;
	logic                   wr_n_s;
	logic [2:0]             sel_s;
	logic [7:0]             hdata_s;

	// pixel clock must stay well below a quarter of clk_sys for edges to be seen
	tcp_sync #(
		.W   (`TCP_SYNC_W),
		.RST (`TCP_SYNC_RST)
	) u_sync (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.pin_i   ({pix_clk, blank_n, pix_data, host_rd_n, host_wr_n, reg_select, host_d_i}),
		.sync_o  (sync_s)
	);

	assign {pclk_s, blank_n_s, pdata_s, rd_n_s, wr_n_s, sel_s, hdata_s} = sync_s;

	// ---------------- host side ----------------
	logic        rd_n_p_q;
	logic        wr_n_p_q;
	logic        rd_start;
	logic        rd_end;
	logic        wr_end;
	logic [2:0]  eff_sel;
	logic [7:0]  ptr_q;
	logic [1:0]  col_phase_q;
	logic        ovl_mode_q;
	logic [7:0]  hold_q [3];
	logic [7:0]  cmd_a_q;
	logic [7:0]  cmd_b_q;
	logic [7:0]  pmask_q;
	logic [7:0]  omask_q;
	logic [2:0]  rd_cnt_q;
	logic        redirect_q;
	logic        xfer_st_q;
	logic        xfer_ld_q;
	logic        is_ptr_wr;
	logic        is_ptr_rd;
	logic        is_data;
	logic        ext_on;
	logic [7:0]  mask_rd;
	logic [23:0] pal_q [256];
	logic [23:0] ovl_q [16];
	logic [23:0] entry;

	assign rd_start = rd_n_p_q && !rd_n_s;
	assign rd_end   = !rd_n_p_q && rd_n_s;
	assign wr_end   = !wr_n_p_q && wr_n_s;
	assign eff_sel  = {sel_s[2] | cmd_a_q[`TCP_A_FORCE_TOP_BIT], sel_s[1:0]};
	assign ext_on   = cmd_a_q[`TCP_A_EXT_ACCESS_BIT];
	assign second_command = cmd_b_q;

	assign is_ptr_wr = (eff_sel == `TCP_SEL_PAL_WPTR) || (eff_sel == `TCP_SEL_OVL_WPTR);
	assign is_ptr_rd = (eff_sel == `TCP_SEL_PAL_RPTR) || (eff_sel == `TCP_SEL_OVL_RPTR);
	assign is_data   = (eff_sel == `TCP_SEL_PAL_DATA) || (eff_sel == `TCP_SEL_OVL_DATA);

	assign entry = ovl_mode_q ? ovl_q[ptr_q[3:0]] : pal_q[ptr_q];

	always_comb begin
		mask_rd = pmask_q;
		if (ext_on) begin
			case (ptr_q)
				`TCP_OFF_OVERLAY_MASK: mask_rd = omask_q;
				`TCP_OFF_SECOND_CMD:   mask_rd = cmd_b_q;
				default:               mask_rd = pmask_q;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rd_n_p_q <= 1'b1;
			wr_n_p_q <= 1'b1;
		end else begin
			rd_n_p_q <= rd_n_s;
			wr_n_p_q <= wr_n_s;
		end
	end

	// pointer, colour phase and transfer requests
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ptr_q       <= 8'h00;
			col_phase_q <= 2'h0;
			ovl_mode_q  <= 1'b0;
			xfer_st_q   <= 1'b0;
			xfer_ld_q   <= 1'b0;
		end else begin
			xfer_st_q <= 1'b0;
			xfer_ld_q <= 1'b0;
			if (wr_end && (is_ptr_wr || is_ptr_rd)) begin
				ptr_q       <= hdata_s;
				col_phase_q <= 2'h0;
				ovl_mode_q  <= eff_sel[2];
				xfer_ld_q   <= is_ptr_rd;
			end else if ((wr_end || rd_end) && is_data) begin
				if (col_phase_q == `TCP_PHASE_BLUE) begin
					col_phase_q <= 2'h0;
					xfer_st_q   <= wr_end;
					xfer_ld_q   <= rd_end;
				end else begin
					col_phase_q <= col_phase_q + 2'h1;
				end
			end
			// transfers run the cycle after a strobe ends, never during one
			if (xfer_st_q || xfer_ld_q) begin
				ptr_q <= ptr_q + 8'h01;
			end
		end
	end

	// colour holding registers
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			hold_q[0] <= 8'h00;
			hold_q[1] <= 8'h00;
			hold_q[2] <= 8'h00;
		end else if (xfer_ld_q) begin
			{hold_q[0], hold_q[1], hold_q[2]} <= entry;
		end else if (wr_end && is_data) begin
			hold_q[col_phase_q] <= hdata_s;
		end
	end

	// colour storage has no reset; software loads it
	always_ff @(posedge clk_sys) begin
		if (xfer_st_q) begin
			if (ovl_mode_q) begin
				ovl_q[ptr_q[3:0]] <= {hold_q[0], hold_q[1], hold_q[2]};
			end else begin
				pal_q[ptr_q] <= {hold_q[0], hold_q[1], hold_q[2]};
			end
		end
	end

	// control registers and the four-read redirect
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cmd_a_q    <= `TCP_RST_CMD_A;
			cmd_b_q    <= `TCP_RST_SECOND_CMD;
			pmask_q    <= `TCP_RST_PIXEL_MASK;
			omask_q    <= `TCP_RST_OVERLAY_MASK;
			rd_cnt_q   <= 3'h0;
			redirect_q <= 1'b0;
		end else if (rd_end) begin
			if (eff_sel == `TCP_SEL_MASK) begin
				if (rd_cnt_q != `TCP_MASK_READS) begin
					rd_cnt_q <= rd_cnt_q + 3'h1;
				end
				if (rd_cnt_q == `TCP_MASK_READS - 3'h1) begin
					redirect_q <= 1'b1;
				end
			end else begin
				rd_cnt_q <= 3'h0;
			end
		end else if (wr_end) begin
			rd_cnt_q   <= 3'h0;
			redirect_q <= 1'b0;
			case (eff_sel)
				`TCP_SEL_CMD_A: cmd_a_q <= hdata_s;
				`TCP_SEL_MASK: begin
					if (redirect_q) begin
						cmd_a_q <= hdata_s;
					end else if (ext_on && ptr_q == `TCP_OFF_OVERLAY_MASK) begin
						omask_q <= hdata_s;
					end else if (ext_on && ptr_q == `TCP_OFF_SECOND_CMD) begin
						cmd_b_q <= hdata_s;
					end else begin
						pmask_q <= hdata_s;
					end
				end
				default: ;
			endcase
		end
	end

	// read data is fixed at the strobe's start and held while it lasts
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			host_d_o <= 8'h00;
		end else if (rd_start) begin
			if (is_ptr_wr || is_ptr_rd) begin
				host_d_o <= ptr_q;
			end else if (is_data) begin
				host_d_o <= hold_q[col_phase_q];
			end else if (eff_sel == `TCP_SEL_CMD_A) begin
				host_d_o <= cmd_a_q;
			end else begin
				host_d_o <= mask_rd;
			end
		end
	end

	assign host_d_oe_n = rd_n_s || rd_start; // wait for the loaded read data

	// ---------------- pixel side ----------------
	tcp_pkg::tcp_mode_t     mode;
	tcp_pkg::tcp_pix_word_t pix_word;
	tcp_pkg::tcp_pix_word_t fifo_word;
	logic        pclk_p_q;
	logic        rise;
	logic        fall;
	logic        dual;
	logic [1:0]  last_ph;
	logic [1:0]  byte_ph_q;
	logic [31:0] asm_q;
	logic [31:0] cur;
	logic        take;
	logic        push;
	logic        fifo_valid;
	logic        pop;
	logic [7:0]  idx_m;

	assign mode = cmd_a_q[`TCP_A_MODE_HI:`TCP_A_MODE_LO];
	assign rise = pclk_s && !pclk_p_q;
	assign fall = !pclk_s && pclk_p_q;
	assign dual = (mode == `TCP_MODE_555_DUAL) || (mode == `TCP_MODE_565_DUAL)
		|| (mode == `TCP_MODE_32_DUAL);

	always_comb begin
		case (mode)
			`TCP_MODE_555_DUAL, `TCP_MODE_555_SINGLE,
			`TCP_MODE_565_DUAL, `TCP_MODE_565_SINGLE: last_ph = 2'h1;
			`TCP_MODE_24_SINGLE:                      last_ph = 2'h2;
			`TCP_MODE_32_DUAL:                        last_ph = 2'h3;
			default:                                  last_ph = 2'h0;
		endcase
	end

	// dual edge: even phases on rising, odd phases on falling edges
	assign take = blank_n_s && (dual ? ((rise && !byte_ph_q[0]) || (fall && byte_ph_q[0]))
		: rise);
	// the phase counter is the pipeline clock divider; a push is one pipeline tick
	assign push = take && (byte_ph_q == last_ph);

	always_comb begin
		cur = asm_q;
		cur[8*byte_ph_q +: 8] = pdata_s;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pclk_p_q  <= 1'b0;
			byte_ph_q <= 2'h0;
			asm_q     <= 32'h0000_0000;
		end else begin
			pclk_p_q <= pclk_s;
			if (!blank_n_s) begin
				byte_ph_q <= 2'h0;
			end else if (take) begin
				asm_q     <= cur;
				byte_ph_q <= push ? 2'h0 : byte_ph_q + 2'h1;
			end
		end
	end

	always_comb begin
		pix_word        = '0;
		pix_word.pseudo = 1'b0;
		case (mode)
			`TCP_MODE_555_DUAL, `TCP_MODE_555_SINGLE: begin
				pix_word.color.red   = {cur[14:10], 3'h0};
				pix_word.color.green = {cur[9:5], 3'h0};
				pix_word.color.blue  = {cur[4:0], 3'h0};
			end
			`TCP_MODE_565_DUAL, `TCP_MODE_565_SINGLE: begin
				pix_word.color.red   = {cur[15:11], 3'h0};
				pix_word.color.green = {cur[10:5], 2'h0};
				pix_word.color.blue  = {cur[4:0], 3'h0};
			end
			`TCP_MODE_24_SINGLE, `TCP_MODE_32_DUAL: begin
				pix_word.color.green = cur[15:8];
				if (cmd_a_q[`TCP_A_BGR_BIT]) begin
					pix_word.color.red  = cur[23:16];
					pix_word.color.blue = cur[7:0];
				end else begin
					pix_word.color.red  = cur[7:0];
					pix_word.color.blue = cur[23:16];
				end
				if (mode == `TCP_MODE_32_DUAL) begin
					pix_word.index = cur[31:24];
				end
			end
			default: begin
				pix_word.pseudo = 1'b1;
				pix_word.index  = cur[7:0];
			end
		endcase
	end

	// the pixel port cannot be stalled; pix_in_ready low means pixels are dropped
	tcp_fifo #(
		.W ($bits(tcp_pkg::tcp_pix_word_t)),
		.D (`TCP_FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.arst_n    (arst_n),
		.in_valid  (push),
		.in_ready  (pix_in_ready),
		.in_data   (pix_word),
		.out_valid (fifo_valid),
		.out_ready (pop),
		.out_data  (fifo_word)
	);

	assign idx_m = fifo_word.index & pmask_q;
	// a store to colour storage freezes the output for that cycle
	assign pop = fifo_valid && (!dac_valid || dac_ready) && !xfer_st_q;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			dac_rgb   <= '0;
			dac_valid <= 1'b0;
		end else begin
			if (pop) begin
				dac_valid <= 1'b1;
				if (fifo_word.pseudo || idx_m != 8'h00) begin
					dac_rgb <= pal_q[idx_m];
				end else begin
					dac_rgb <= fifo_word.color;
				end
			end else if (dac_ready) begin
				dac_valid <= 1'b0;
			end
		end
	end

endmodule : tcp_top

`default_nettype wire

/* File: tb/tcp_top_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module tcp_top_monitor (
	input wire logic              clk_sys,         // clock
	input wire logic              arst_n,          // reset
	input wire logic              pix_clk,         // pixel clock pin
	input wire logic              blank_n,         // blanking pin
	input wire logic [7:0]        pix_data,        // pixel port
	input wire logic              host_rd_n,       // read strobe
	input wire logic              host_wr_n,       // write strobe
	input wire logic [2:0]        reg_select,      // select
	input wire logic [7:0]        host_d_i,        // write data
	input wire logic [7:0]        host_d_o,        // read data
	input wire logic              host_d_oe_n,     // read drive
	input wire tcp_pkg::tcp_rgb_t dac_rgb,         // colour
	input wire logic              dac_valid,       // colour valid
	input wire logic              dac_ready,       // consumer ready
	input wire logic              pix_in_ready,    // fifo room
	input wire logic [7:0]        second_command   // second command
);
	// age of the last write strobe, saturating so idle time never wraps into a false cause
	logic [3:0] wr_age_q;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			wr_age_q <= 4'hf;
		else if (!host_wr_n)
			wr_age_q <= 4'h0;
		else if (wr_age_q != 4'hf)
			wr_age_q <= wr_age_q + 4'h1;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	sequence rd_held;
		!host_rd_n [*4];
	endsequence
	sequence wr_only;
		(!host_wr_n && host_rd_n) [*8];
	endsequence

	chk_oe_on_read: assert property (rd_held |-> ##[0:2] !host_d_oe_n)
		else $error("read strobe not answered");
	chk_oe_idle: assert property (host_rd_n [*8] |-> host_d_oe_n)
		else $error("data driven without read");
	chk_oe_release: assert property ($rose(host_rd_n) |-> ##[1:6] host_d_oe_n)
		else $error("data bus not released");
	chk_oe_on_write: assert property (wr_only |-> host_d_oe_n)
		else $error("data driven during write");
	chk_dout_stable: assert property (!host_d_oe_n && $past(!host_d_oe_n) |-> $stable(host_d_o))
		else $error("read data moved during read");
	chk_colour_hold: assert property (dac_valid && !dac_ready |=> dac_valid && $stable(dac_rgb))
		else $error("colour dropped before accept");
	chk_colour_cause: assert property ($changed(dac_rgb) |-> ##[0:1] dac_valid)
		else $error("colour changed without valid");
	chk_second_cmd_cause: assert property ($changed(second_command) |-> wr_age_q < 4'hc)
		else $error("second command changed without write");
endmodule : tcp_top_monitor

bind tcp_top tcp_top_monitor u_tcp_top_monitor (.clk_sys(clk_sys), .arst_n(arst_n),
	.pix_clk(pix_clk), .blank_n(blank_n), .pix_data(pix_data), .host_rd_n(host_rd_n),
	.host_wr_n(host_wr_n), .reg_select(reg_select), .host_d_i(host_d_i),
	.host_d_o(host_d_o), .host_d_oe_n(host_d_oe_n), .dac_rgb(dac_rgb),
	.dac_valid(dac_valid), .dac_ready(dac_ready), .pix_in_ready(pix_in_ready),
	.second_command(second_command));

`default_nettype wire

/* File: tb/tcp_pix_source.sv */
`timescale 1ns/1ps
`default_nettype none

module tcp_pix_source (
	input  wire logic       clk_sys,   // clock
	input  wire logic       arst_n,    // reset
	input  wire logic       dual,      // bytes on both edges
	output logic            pix_clk,   // pixel clock
	output logic            blank_n,   // low blanks
	output logic      [7:0] pix_data   // pixel byte
);
	logic [3:0] ph;
	logic [7:0] q[$];

	task automatic push_byte(input logic [7:0] b);
		q.push_back(b);
	endtask : push_byte

	// bytes change three cycles before each edge so they are settled when sampled
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ph <= 4'h0;
			pix_clk <= 1'b0;
			blank_n <= 1'b0;
			pix_data <= 8'h00;
		end else begin
			ph <= (ph == 4'hb) ? 4'h0 : ph + 4'h1;
			if (ph == 4'hb)
				pix_clk <= 1'b1;
			if (ph == 4'h5)
				pix_clk <= 1'b0;
			if (ph == 4'h8) begin
				if (q.size() > 0) begin
					blank_n <= 1'b1;
					pix_data <= q.pop_front();
				end else begin
					blank_n <= 1'b0;
					pix_data <= ~pix_data;
				end
			end
			if (ph == 4'h2 && dual) begin
				if (blank_n && q.size() > 0)
					pix_data <= q.pop_front();
				else begin
					blank_n <= 1'b0;
					pix_data <= ~pix_data;
				end
			end
		end
	end
endmodule : tcp_pix_source

`default_nettype wire

/* File: tb/test_tcp_top.sv */
`timescale 1ns/1ps
`default_nettype none

module test_tcp_top;
	logic clk_sys, arst_n, host_rd_n, host_wr_n, dac_ready, dual, saw_full;
	logic pix_clk, blank_n, host_d_oe_n, dac_valid, pix_in_ready;
	logic [2:0] reg_select;
	logic [7:0] hd_drv, host_d_o, pix_data, second_command;
	wire  [7:0] host_d_i;
	tcp_pkg::tcp_rgb_t dac_rgb;
	tcp_pkg::tcp_rgb_t rx[$];
	int failures = 0;
	int num_checks = 0;

	// the shared data wire: the device wins while it drives
	assign host_d_i = host_d_oe_n ? hd_drv : host_d_o;

	tcp_top u_tcp_top (.clk_sys(clk_sys), .arst_n(arst_n), .pix_clk(pix_clk),
		.blank_n(blank_n), .pix_data(pix_data), .host_rd_n(host_rd_n),
		.host_wr_n(host_wr_n), .reg_select(reg_select), .host_d_i(host_d_i),
		.host_d_o(host_d_o), .host_d_oe_n(host_d_oe_n), .dac_rgb(dac_rgb),
		.dac_valid(dac_valid), .dac_ready(dac_ready), .pix_in_ready(pix_in_ready),
		.second_command(second_command));
	tcp_pix_source u_tcp_pix_source (.clk_sys(clk_sys), .arst_n(arst_n), .dual(dual),
		.pix_clk(pix_clk), .blank_n(blank_n), .pix_data(pix_data));

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		if (dac_valid === 1'b1 && dac_ready)
			rx.push_back(dac_rgb);
		if (pix_in_ready === 1'b0)
			saw_full <= 1'b1;
	end

	task automatic complete_run;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run

	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			failures++;
		end
	endtask : check

	task automatic wr(input logic [2:0] s, input logic [7:0] d);
		@(posedge clk_sys);
		reg_select <= s;
		hd_drv <= d;
		host_wr_n <= 1'b0;
		repeat (8) @(posedge clk_sys);
		host_wr_n <= 1'b1;
		repeat (8) @(posedge clk_sys);
		hd_drv <= ~d;
	endtask : wr

	task automatic rc(input logic [2:0] s, input logic [7:0] e);
		@(posedge clk_sys);
		reg_select <= s;
		host_rd_n <= 1'b0;
		repeat (8) @(posedge clk_sys);
		check({16'h0, host_d_o}, {16'h0, e});
		host_rd_n <= 1'b1;
		repeat (8) @(posedge clk_sys);
	endtask : rc

	// byte 0 of b goes first on the port
	task automatic run_pix(input logic [7:0] c, input int n, input logic [31:0] b,
		input logic [23:0] e);
		int k;
		wr(3'h6, c);
		dual <= (c[7:4] == 4'h1) || (c[7:4] == 4'h3) || (c[7:4] == 4'h6);
		@(posedge clk_sys);
		rx.delete();
		for (k = 0; k < n; k++)
			u_tcp_pix_source.push_byte(b[8*k +: 8]);
		k = 0;
		while (rx.size() == 0 && k < 400) begin
			@(posedge clk_sys);
			k++;
		end
		check((rx.size() > 0) ? rx[0] : ~e, e);
	endtask : run_pix

	initial begin
		repeat (30000) @(posedge clk_sys);
		failures++;
		complete_run();
	end

	initial begin
		arst_n = 1'b0;
		host_rd_n = 1'b1;
		host_wr_n = 1'b1;
		reg_select = 3'h0;
		hd_drv = 8'h00;
		dac_ready = 1'b1;
		dual = 1'b0;
		saw_full = 1'b0;
		repeat (20) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (5) @(posedge clk_sys);
		check({16'h0, second_command}, 24'h0);
		check({22'h0, host_d_oe_n, pix_in_ready}, 24'h3);
		rc(3'h2, 8'hff);
		wr(3'h0, 8'hff);
		wr(3'h1, 8'ha1);
		wr(3'h1, 8'hb2);
		wr(3'h1, 8'hc3);
		rc(3'h0, 8'h00);
		rc(3'h3, 8'h00);
		wr(3'h3, 8'hff);
		rc(3'h3, 8'h00);
		rc(3'h1, 8'ha1);
		rc(3'h1, 8'hb2);
		rc(3'h1, 8'hc3);
		wr(3'h0, 8'h05);
		wr(3'h1, 8'hee);
		wr(3'h0, 8'h05);
		wr(3'h1, 8'h01);
		wr(3'h1, 8'h02);
		wr(3'h1, 8'h03);
		wr(3'h3, 8'h05);
		rc(3'h1, 8'h01);
		rc(3'h0, 8'h06);
		rc(3'h1, 8'h02);
		rc(3'h1, 8'h03);
		repeat (4) rc(3'h2, 8'hff);
		wr(3'h2, 8'h01);
		rc(3'h6, 8'h01);
		wr(3'h0, 8'h02);
		wr(3'h2, 8'h5a);
		check({16'h0, second_command}, 24'h5a);
		rc(3'h2, 8'h5a);
		wr(3'h0, 8'h01);
		wr(3'h2, 8'h0f);
		rc(3'h2, 8'h0f);
		wr(3'h0, 8'h00);
		rc(3'h2, 8'hff);
		wr(3'h6, 8'h00);
		repeat (4) rc(3'h2, 8'hff);
		wr(3'h0, 8'h00);
		wr(3'h2, 8'h77);
		rc(3'h6, 8'h00);
		rc(3'h2, 8'h77);
		wr(3'h6, 8'h04);
		rc(3'h2, 8'h04);
		wr(3'h0, 8'h13);
		wr(3'h1, 8'h44);
		wr(3'h1, 8'h55);
		wr(3'h1, 8'h66);
		rc(3'h3, 8'h14);
		wr(3'h3, 8'h03);
		rc(3'h1, 8'h44);
		rc(3'h1, 8'h55);
		rc(3'h1, 8'h66);
		wr(3'h2, 8'h00);
		rc(3'h6, 8'h00);
		run_pix(8'h30, 2, 32'h1234, 24'h1044a0);
		run_pix(8'h40, 2, 32'h1234, 24'h1044a0);
		run_pix(8'h10, 2, 32'h1234, 24'h2088a0);
		run_pix(8'h20, 2, 32'h9234, 24'h2088a0);
		run_pix(8'h50, 3, 32'hccbbaa, 24'haabbcc);
		run_pix(8'h52, 3, 32'hccbbaa, 24'hccbbaa);
		run_pix(8'h60, 4, 32'h00332211, 24'h112233);
		run_pix(8'h60, 4, 32'h05332211, 24'h010203);
		run_pix(8'h00, 1, 32'h05, 24'h010203);
		wr(3'h2, 8'h00);
		run_pix(8'h60, 4, 32'h05332211, 24'h112233);
		// a lone byte then blanking: the next pixel must start at byte zero again
		wr(3'h6, 8'h40);
		dual <= 1'b0;
		u_tcp_pix_source.push_byte(8'hff);
		repeat (30) @(posedge clk_sys);
		run_pix(8'h40, 2, 32'h1234, 24'h1044a0);
		wr(3'h6, 8'h30);
		dual <= 1'b1;
		dac_ready <= 1'b0;
		@(posedge clk_sys);
		rx.delete();
		repeat (40) begin
			u_tcp_pix_source.push_byte(8'h34);
			u_tcp_pix_source.push_byte(8'h12);
		end
		repeat (700) @(posedge clk_sys);
		dac_ready <= 1'b1;
		repeat (300) @(posedge clk_sys);
		check({23'h0, saw_full}, 24'h1);
		check({23'h0, rx.size() >= 32 && rx.size() < 40}, 24'h1);
		check((rx.size() > 0) ? rx[0] : 24'h0, 24'h1044a0);
		complete_run();
	end
endmodule : test_tcp_top

`default_nettype wire
